// file: design/rf_pkg.sv
package rf_pkg;

   localparam int DATA_W = 8;
   localparam int SEL_W  = 3;

   // Status flag bit positions
   localparam logic [2:0] FLAG_C = 3'h0;
   localparam logic [2:0] FLAG_Z = 3'h1;
   localparam logic [2:0] FLAG_N = 3'h2;
   localparam logic [2:0] FLAG_V = 3'h3;
   localparam logic [2:0] FLAG_S = 3'h4;
   localparam logic [2:0] FLAG_H = 3'h5;
   localparam logic [2:0] FLAG_T = 3'h6;
   localparam logic [2:0] FLAG_I = 3'h7;

   localparam logic [7:0] FLAGS_RESET  = 8'h00;
   localparam logic [7:0] RESULT_RESET = 8'h00;
   localparam logic [7:0] ZERO_BYTE    = 8'h00;
   localparam logic [7:0] ONE_HOT_LSB  = 8'h01;
   localparam int         MSB          = 7;

   typedef enum logic [3:0] {
      OP_NOP                 = 4'h0,
      OP_ROTATE_LEFT_CARRY   = 4'h1,
      OP_ROTATE_RIGHT_CARRY  = 4'h2,
      OP_BIT_TO_TRANSFER     = 4'h3,
      OP_TRANSFER_TO_BIT     = 4'h4,
      OP_FLAG_SET            = 4'h5,
      OP_FLAG_CLEAR          = 4'h6,
      OP_SLEEP               = 4'h7,
      OP_WATCHDOG_RESTART_OP = 4'h8
   } op_t;

   typedef struct packed {
      logic [7:0] status_flags_register;
      logic [7:0] result;
      logic       result_we;
      logic       sleep_req;
      logic       wdr_req;
      logic       done;
   } unit_state_t;

endpackage

// file: design/dp_if.sv
`timescale 1ns/1ns
interface dp_if;
   rf_pkg::op_t op;
   logic [7:0]  operand;
   logic [2:0]  bit_sel;
   logic [7:0]  flags_in;
   logic [7:0]  result;
   logic [7:0]  flags_out;
   logic        result_we;

   modport core (output op, operand, bit_sel, flags_in, input result, flags_out, result_we);
   modport unit (input op, operand, bit_sel, flags_in, output result, flags_out, result_we);
endinterface

// file: design/bit_datapath.sv
`timescale 1ns/1ns
module bit_datapath (
   dp_if.unit dp
);

   logic [7:0] inserted;

   // Transfer bit dropped into the selected position
   for (genvar i = 0; i < rf_pkg::DATA_W; i++) begin : g_insert
      assign inserted[i] = (dp.bit_sel == 3'(i)) ? dp.flags_in[rf_pkg::FLAG_T] : dp.operand[i];
   end

   always_comb begin
      logic [7:0] r;
      logic       c;
      r            = dp.operand;
      c            = dp.flags_in[rf_pkg::FLAG_C];
      dp.result    = dp.operand;
      dp.flags_out = dp.flags_in;
      dp.result_we = 1'b0;
      case (dp.op)
         rf_pkg::OP_ROTATE_LEFT_CARRY, rf_pkg::OP_ROTATE_RIGHT_CARRY: begin
            if (dp.op == rf_pkg::OP_ROTATE_LEFT_CARRY) begin
               r = {dp.operand[6:0], dp.flags_in[rf_pkg::FLAG_C]}; // [RULE1]
               c = dp.operand[rf_pkg::MSB];                        // [RULE1]
            end else begin
               r = {dp.flags_in[rf_pkg::FLAG_C], dp.operand[7:1]}; // [RULE2]
               c = dp.operand[0];                                  // [RULE2]
            end
            dp.result                    = r;
            dp.result_we                 = 1'b1;
            dp.flags_out[rf_pkg::FLAG_C] = c;
            dp.flags_out[rf_pkg::FLAG_Z] = (r == rf_pkg::ZERO_BYTE);
            dp.flags_out[rf_pkg::FLAG_N] = r[rf_pkg::MSB];
            dp.flags_out[rf_pkg::FLAG_V] = r[rf_pkg::MSB] ^ c;
         end
         rf_pkg::OP_BIT_TO_TRANSFER: begin
            dp.flags_out[rf_pkg::FLAG_T] = dp.operand[dp.bit_sel]; // [RULE3]
         end
         rf_pkg::OP_TRANSFER_TO_BIT: begin
            dp.result    = inserted;                               // [RULE4]
            dp.result_we = 1'b1;
         end
         rf_pkg::OP_FLAG_SET: begin
            dp.flags_out[dp.bit_sel] = 1'b1; // [RULE5] [RULE6] [RULE8] [RULE10] [RULE14]
         end
         rf_pkg::OP_FLAG_CLEAR: begin
            dp.flags_out[dp.bit_sel] = 1'b0; // [RULE5] [RULE7] [RULE9] [RULE11] [RULE14]
         end
         default: begin
            dp.result_we = 1'b0;
         end
      endcase
   end

endmodule

// file: design/rotate_and_flag_unit.sv
// Overview of operation
// RULE1: Rotate left through carry puts old carry in bit 0, shifts up, old bit 7 to carry, sets Z C N V, in one cycle.
// RULE2: Rotate right through carry puts old carry in bit 7, shifts down, old bit 0 to carry, sets Z C N V, in one cycle.
// RULE3: Bit store copies the selected source bit into the transfer flag only, in one cycle.
// RULE4: Bit load writes the transfer flag into the selected destination bit, flags untouched, in one cycle.
// RULE5: Carry set and carry clear force only the carry flag, each in one cycle.
// RULE6: Sign set forces only the signed-test flag to one in one cycle.
// RULE7: Sign clear forces only the signed-test flag to zero in one cycle.
// RULE8: Overflow set forces only the overflow flag to one in one cycle.
// RULE9: Overflow clear forces only the overflow flag to zero in one cycle.
// RULE10: Half-carry set forces only the half-carry flag to one in one cycle.
// RULE11: Half-carry clear forces only the half-carry flag to zero in one cycle.
// RULE12: Sleep takes one cycle, keeps all flags and requests sleep from power management.
// RULE13: Watchdog restart takes one cycle, keeps all flags and pulses a restart request.
// RULE14: Negative, zero, transfer and interrupt-enable set or clear touch only their bit; no-op changes nothing.
`timescale 1ns/1ns
module rotate_and_flag_unit (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Decoded instruction
   input  wire logic        op_valid,
   input  wire rf_pkg::op_t op_code,
   input  wire logic [7:0]  operand,
   input  wire logic [2:0]  bit_sel,
   // Register file write-back
   output logic [7:0]       result_q,
   output logic             result_we_q,
   // Status and control
   output logic [7:0]       status_flags_q,
   output logic             sleep_req_q,
   output logic             wdr_req_q,
   output logic             done_q
);

   ////////////////////////////////////////////////////////////////////////////////
   // Datapath
   dp_if dp ();

   rf_pkg::unit_state_t st_q;
   rf_pkg::unit_state_t st_d;

   assign dp.op       = op_valid ? op_code : rf_pkg::OP_NOP;
   assign dp.operand  = operand;
   assign dp.bit_sel  = bit_sel;
   assign dp.flags_in = st_q.status_flags_register;

   bit_datapath u_dp (
      .dp (dp.unit)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // State
   always_comb begin
      st_d           = st_q;
      st_d.result_we = 1'b0;
      st_d.sleep_req = 1'b0;
      st_d.wdr_req   = 1'b0;
      st_d.done      = op_valid;
      if (op_valid) begin
         st_d.status_flags_register = dp.flags_out;
         st_d.result_we             = dp.result_we;
         if (dp.result_we) begin
            st_d.result = dp.result;
         end
         st_d.sleep_req = (op_code == rf_pkg::OP_SLEEP);               // [RULE12]
         st_d.wdr_req   = (op_code == rf_pkg::OP_WATCHDOG_RESTART_OP); // [RULE13]
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q.status_flags_register <= rf_pkg::FLAGS_RESET;
         st_q.result                <= rf_pkg::RESULT_RESET;
         st_q.result_we             <= 1'b0;
         st_q.sleep_req             <= 1'b0;
         st_q.wdr_req               <= 1'b0;
         st_q.done                  <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   assign result_q       = st_q.result;
   assign result_we_q    = st_q.result_we;
   assign status_flags_q = st_q.status_flags_register;
   assign sleep_req_q    = st_q.sleep_req;
   assign wdr_req_q      = st_q.wdr_req;
   assign done_q         = st_q.done;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_issue(rf_pkg::op_t o);
      op_valid && op_code == o;
   endsequence

   sequence s_flag_issue(rf_pkg::op_t o, logic [2:0] idx);
      op_valid && op_code == o && bit_sel == idx;
   endsequence

   property p_rotate_left;
      s_issue(rf_pkg::OP_ROTATE_LEFT_CARRY) |=>
         result_we_q && done_q
         && result_q == {$past(operand[6:0]), $past(status_flags_q[0])}
         && status_flags_q[0] == $past(operand[7])
         && status_flags_q[1] == (result_q == 8'h00)
         && status_flags_q[3] == (result_q[7] ^ status_flags_q[0])
         && status_flags_q[7:4] == $past(status_flags_q[7:4]);
   endproperty
   a_rotate_left: assert property (p_rotate_left) // [RULE1]
      else $error("rotate left result or flags wrong");

   property p_rotate_right;
      s_issue(rf_pkg::OP_ROTATE_RIGHT_CARRY) |=>
         result_we_q && done_q
         && result_q == {$past(status_flags_q[0]), $past(operand[7:1])}
         && status_flags_q[0] == $past(operand[0])
         && status_flags_q[1] == (result_q == 8'h00)
         && status_flags_q[2] == result_q[7]
         && status_flags_q[3] == (result_q[7] ^ status_flags_q[0])
         && status_flags_q[7:4] == $past(status_flags_q[7:4]);
   endproperty
   a_rotate_right: assert property (p_rotate_right) // [RULE2]
      else $error("rotate right result or flags wrong");

   property p_bit_store;
      s_issue(rf_pkg::OP_BIT_TO_TRANSFER) |=>
         !result_we_q
         && status_flags_q[6] == $past(operand[bit_sel])
         && (status_flags_q & 8'hBF) == ($past(status_flags_q) & 8'hBF);
   endproperty
   a_bit_store: assert property (p_bit_store) // [RULE3]
      else $error("bit store wrong");

   property p_bit_load;
      s_issue(rf_pkg::OP_TRANSFER_TO_BIT) |=>
         result_we_q && status_flags_q == $past(status_flags_q)
         && result_q[$past(bit_sel)] == status_flags_q[6]
         && (result_q & ~(8'h01 << $past(bit_sel)))
            == ($past(operand) & ~(8'h01 << $past(bit_sel)));
   endproperty
   a_bit_load: assert property (p_bit_load) // [RULE4]
      else $error("bit load wrong");

   property p_flag_force(rf_pkg::op_t o, logic [2:0] idx, logic v);
      s_flag_issue(o, idx) |=> done_q && !result_we_q
         && status_flags_q[idx] == v
         && (status_flags_q & ~(8'h01 << idx)) == ($past(status_flags_q) & ~(8'h01 << idx));
   endproperty
   a_carry_set: assert property (p_flag_force(rf_pkg::OP_FLAG_SET, 3'h0, 1'b1)) // [RULE5]
      else $error("carry set wrong");
   a_carry_clear: assert property (p_flag_force(rf_pkg::OP_FLAG_CLEAR, 3'h0, 1'b0)) // [RULE5]
      else $error("carry clear wrong");
   a_sign_set: assert property (p_flag_force(rf_pkg::OP_FLAG_SET, 3'h4, 1'b1)) // [RULE6]
      else $error("sign set wrong");
   a_sign_clear: assert property (p_flag_force(rf_pkg::OP_FLAG_CLEAR, 3'h4, 1'b0)) // [RULE7]
      else $error("sign clear wrong");
   a_ovf_set: assert property (p_flag_force(rf_pkg::OP_FLAG_SET, 3'h3, 1'b1)) // [RULE8]
      else $error("overflow set wrong");
   a_ovf_clear: assert property (p_flag_force(rf_pkg::OP_FLAG_CLEAR, 3'h3, 1'b0)) // [RULE9]
      else $error("overflow clear wrong");
   a_half_set: assert property (p_flag_force(rf_pkg::OP_FLAG_SET, 3'h5, 1'b1)) // [RULE10]
      else $error("half carry set wrong");
   a_half_clear: assert property (p_flag_force(rf_pkg::OP_FLAG_CLEAR, 3'h5, 1'b0)) // [RULE11]
      else $error("half carry clear wrong");
   a_int_set: assert property (p_flag_force(rf_pkg::OP_FLAG_SET, 3'h7, 1'b1)) // [RULE14]
      else $error("interrupt enable set wrong");
   a_int_clear: assert property (p_flag_force(rf_pkg::OP_FLAG_CLEAR, 3'h7, 1'b0)) // [RULE14]
      else $error("interrupt enable clear wrong");
   a_neg_set: assert property (p_flag_force(rf_pkg::OP_FLAG_SET, 3'h2, 1'b1)) // [RULE14]
      else $error("negative set wrong");
   a_neg_clear: assert property (p_flag_force(rf_pkg::OP_FLAG_CLEAR, 3'h2, 1'b0)) // [RULE14]
      else $error("negative clear wrong");
   a_zero_set: assert property (p_flag_force(rf_pkg::OP_FLAG_SET, 3'h1, 1'b1)) // [RULE14]
      else $error("zero set wrong");
   a_zero_clear: assert property (p_flag_force(rf_pkg::OP_FLAG_CLEAR, 3'h1, 1'b0)) // [RULE14]
      else $error("zero clear wrong");
   a_tbit_set: assert property (p_flag_force(rf_pkg::OP_FLAG_SET, 3'h6, 1'b1)) // [RULE14]
      else $error("transfer bit set wrong");
   a_tbit_clear: assert property (p_flag_force(rf_pkg::OP_FLAG_CLEAR, 3'h6, 1'b0)) // [RULE14]
      else $error("transfer bit clear wrong");

   property p_write_source;
      result_we_q |-> $past(op_valid)
         && ($past(op_code) == rf_pkg::OP_ROTATE_LEFT_CARRY
            || $past(op_code) == rf_pkg::OP_ROTATE_RIGHT_CARRY
            || $past(op_code) == rf_pkg::OP_TRANSFER_TO_BIT);
   endproperty
   a_write_source: assert property (p_write_source) // [RULE3]
      else $error("write strobe from an op that does not write");

   property p_idle;
      !op_valid |=> !done_q && !result_we_q && !sleep_req_q && !wdr_req_q
         && status_flags_q == $past(status_flags_q) && result_q == $past(result_q);
   endproperty
   a_idle: assert property (p_idle) // [RULE14]
      else $error("idle cycle changed state");

   property p_sleep;
      s_issue(rf_pkg::OP_SLEEP) |=> sleep_req_q && !wdr_req_q
         && status_flags_q == $past(status_flags_q);
   endproperty
   a_sleep: assert property (p_sleep) // [RULE12]
      else $error("sleep request wrong");

   property p_watchdog;
      s_issue(rf_pkg::OP_WATCHDOG_RESTART_OP) ##1 !op_valid |->
         wdr_req_q ##1 !wdr_req_q;
   endproperty
   a_watchdog: assert property (p_watchdog) // [RULE13]
      else $error("watchdog restart not a single pulse");

   property p_nop;
      s_issue(rf_pkg::OP_NOP) |=> !result_we_q && !sleep_req_q && !wdr_req_q
         && status_flags_q == $past(status_flags_q) && result_q == $past(result_q);
   endproperty
   a_nop: assert property (p_nop) // [RULE14]
      else $error("no-op changed state");

endmodule

// file: tb/reg_file_model.sv
`timescale 1ns/1ns
// Destination register on the register-file side, loaded by write-backs
module reg_file_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Write-back from the unit
   input  wire logic       we,
   input  wire logic [7:0] wdata,
   // Register contents
   output logic [7:0]      dest_q
);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dest_q <= 8'h00;
      end else if (we) begin
         dest_q <= wdata;
      end
   end
endmodule

// file: tb/test_rotate_and_flag_unit.sv
`timescale 1ns/1ns
module test_rotate_and_flag_unit;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        op_valid = 1'b0;
   rf_pkg::op_t op_code = rf_pkg::OP_NOP;
   logic [7:0]  operand = 8'h00;
   logic [2:0]  bit_sel = 3'h0;
   logic [7:0]  result_q;
   logic        result_we_q;
   logic [7:0]  status_flags_q;
   logic        sleep_req_q;
   logic        wdr_req_q;
   logic        done_q;
   logic [7:0]  dest_q;
   logic [7:0]  exp_fl = 8'h00;
   logic [7:0]  exp_res = 8'h00;
   logic [7:0]  v0;
   logic        c0;
   int          err_count = 0;
   int          checks = 0;
   int          cycles = 0;

   rotate_and_flag_unit u_rotate_and_flag_unit (.clk(clk), .rst(rst), .op_valid(op_valid),
      .op_code(op_code), .operand(operand), .bit_sel(bit_sel), .result_q(result_q),
      .result_we_q(result_we_q), .status_flags_q(status_flags_q),
      .sleep_req_q(sleep_req_q), .wdr_req_q(wdr_req_q), .done_q(done_q));

   reg_file_model u_reg_file_model (.clk(clk), .rst(rst), .we(result_we_q),
      .wdata(result_q), .dest_q(dest_q));

   always #50 clk = ~clk;

   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Cycle ceiling well above the roughly 120 cycles the tests need
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         err_count++;
         end_sim();
      end
   end

   task automatic chk(input logic ok, input string m);
      checks++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("Error at %0t: %s", $time, m);
      end
   endtask

   // Issues one op, then checks every output in the cycle after it is taken
   task automatic exec(input rf_pkg::op_t op, input logic [7:0] opd, input logic [2:0] sel);
      logic [7:0] r;
      logic       we;
      logic       rot;
      r = exp_res;
      we = 1'b0;
      rot = 1'b0;
      case (op)
         rf_pkg::OP_ROTATE_LEFT_CARRY: begin
            r = {opd[6:0], exp_fl[0]};
            exp_fl[0] = opd[7];
            rot = 1'b1;
         end
         rf_pkg::OP_ROTATE_RIGHT_CARRY: begin
            r = {exp_fl[0], opd[7:1]};
            exp_fl[0] = opd[0];
            rot = 1'b1;
         end
         rf_pkg::OP_BIT_TO_TRANSFER: exp_fl[6] = opd[sel];
         rf_pkg::OP_TRANSFER_TO_BIT: begin
            r = opd;
            r[sel] = exp_fl[6];
            we = 1'b1;
         end
         rf_pkg::OP_FLAG_SET: exp_fl[sel] = 1'b1;
         rf_pkg::OP_FLAG_CLEAR: exp_fl[sel] = 1'b0;
         default: ;
      endcase
      if (rot) begin
         we = 1'b1;
         exp_fl[1] = (r == 8'h00);
         exp_fl[2] = r[7];
         exp_fl[3] = r[7] ^ exp_fl[0];
      end
      @(posedge clk);
      #10;
      op_valid = 1'b1;
      op_code = op;
      operand = opd;
      bit_sel = sel;
      @(posedge clk);
      #10;
      op_valid = 1'b0;
      operand = ~opd;
      chk(status_flags_q === exp_fl, "flags differ");
      chk(done_q === 1'b1 && result_we_q === we, "done or write strobe wrong");
      chk(result_q === r, "result differs");
      chk(sleep_req_q === (op == rf_pkg::OP_SLEEP), "sleep request wrong");
      chk(wdr_req_q === (op == rf_pkg::OP_WATCHDOG_RESTART_OP), "restart request wrong");
      if (we) begin
         exp_res = r;
      end
   endtask

   initial begin
      repeat (3) @(posedge clk);
      #10;
      rst = 1'b0;
      chk(status_flags_q === 8'h00 && done_q === 1'b0 && result_we_q === 1'b0, "reset");
      $display("Test reset done");
      exec(rf_pkg::OP_ROTATE_LEFT_CARRY, 8'h81, 3'h0);
      exec(rf_pkg::OP_ROTATE_LEFT_CARRY, 8'h00, 3'h0);
      exec(rf_pkg::OP_ROTATE_LEFT_CARRY, 8'h00, 3'h0);
      exec(rf_pkg::OP_ROTATE_RIGHT_CARRY, 8'h01, 3'h0);
      exec(rf_pkg::OP_ROTATE_RIGHT_CARRY, 8'h00, 3'h0);
      $display("Test rotate done");
      for (int i = 0; i < 8; i++) begin
         exec(rf_pkg::OP_FLAG_SET, 8'h00, 3'(i));
      end
      for (int i = 0; i < 8; i++) begin
         exec(rf_pkg::OP_FLAG_CLEAR, 8'hFF, 3'(i));
      end
      $display("Test flag set and clear done");
      for (int i = 0; i < 8; i++) begin
         exec(rf_pkg::OP_BIT_TO_TRANSFER, 8'hA5, 3'(i));
         exec(rf_pkg::OP_TRANSFER_TO_BIT, 8'h3C, 3'(7 - i));
      end
      $display("Test transfer bit done");
      exec(rf_pkg::OP_SLEEP, 8'h00, 3'h0);
      exec(rf_pkg::OP_WATCHDOG_RESTART_OP, 8'h00, 3'h0);
      exec(rf_pkg::OP_NOP, 8'hFF, 3'h7);
      exec(rf_pkg::op_t'(4'hF), 8'hFF, 3'h7);
      @(posedge clk);
      #10;
      chk(done_q === 1'b0 && status_flags_q === exp_fl, "idle cycle changed state");
      $display("Test control ops done");
      // Nine rotates through carry bring the register and carry back
      exec(rf_pkg::OP_FLAG_SET, 8'h00, 3'h0);
      v0 = dest_q;
      c0 = 1'b1;
      for (int i = 0; i < 9; i++) begin
         // Let the register file take the previous write-back first
         @(posedge clk);
         #10;
         exec(rf_pkg::OP_ROTATE_LEFT_CARRY, dest_q, 3'h0);
      end
      @(posedge clk);
      #10;
      chk(dest_q === v0 && status_flags_q[0] === c0, "rotate chain");
      $display("Test rotate chain done");
      end_sim();
   end
endmodule
